// ===== common/csr_defs.svh
// offsets, field positions, reset values and timing counts of the card block
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define CSR_APB_CTRL 8'h00
`define CSR_APB_STATUS 8'h04
`define CSR_APB_XSET 8'h08
`define CSR_APB_INFO 8'h0c
`define CSR_APB_ARG 8'h10
`define CSR_APB_ID_PAGE 3'h1

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define CSR_CTRL_PWR 0
`define CSR_CTRL_VOLT 1
`define CSR_CTRL_LOCK 2
`define CSR_CTRL_DONE 3
`define CSR_CTRL_RST 3'h2
`define CSR_RCA_RST 16'h0000

// ****************************************************************
// card status fields
// ****************************************************************
`define CSR_ST_LOCKED 25
`define CSR_ST_COM_CRC 23
`define CSR_ST_ILLEGAL 22
`define CSR_ST_STATE_LSB 9
`define CSR_ST_BUF_EMPTY 8
`define CSR_C_MASK 32'hfd3fa000

// ****************************************************************
// frames and timing (card clock cycles)
// ****************************************************************
`define CSR_OCR 32'h80ff8000
`define CSR_R3_HEAD 8'h3f
`define CSR_R3_TAIL 8'hff
`define CSR_R2_HEAD 8'h3f
`define CSR_LEN_SHORT 8'h30
`define CSR_LEN_LONG 8'h88
`define CSR_N_CR 3'h2
`define CSR_N_ID 3'h5

`endif

// ===== common/csr_pkg.sv
// types and the crc helper of the card block
package csr_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_READY = 4'h1,
      ST_IDENT = 4'h2,
      ST_STBY = 4'h3,
      ST_TRAN = 4'h4,
      ST_DATA = 4'h5,
      ST_RCV = 4'h6,
      ST_PRG = 4'h7,
      ST_DIS = 4'h8,
      ST_INA = 4'h9
   } csr_state_e;

   typedef enum logic [2:0] {
      R_NONE = 3'h0,
      R_R1 = 3'h1,
      R_R1B = 3'h2,
      R_CID = 3'h3,
      R_CSD = 3'h4,
      R_R3 = 3'h5
   } csr_resp_e;

   // crc7, x^7 + x^3 + 1, msb first
   function automatic logic [6:0] crc7_of(input logic [39:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ 7'h09;
         end
      end
      return c;
   endfunction : crc7_of

endpackage : csr_pkg

// ===== common/csr_tx_if.sv
// link between command decoder and response shifter
`timescale 1ns/1ps
interface csr_tx_if;
   logic start;
   logic [135:0] frame;
   logic [7:0] len;
   logic [2:0] gap;
   logic arb;
   logic rise;
   logic fall;
   logic line;
   logic busy;
   logic done;
   logic lost;
   logic cmd_out;
   logic cmd_oe;

   modport ctl (
      output start, frame, len, gap, arb, rise, fall, line,
      input busy, done, lost, cmd_out, cmd_oe
   );
   modport tx (
      input start, frame, len, gap, arb, rise, fall, line,
      output busy, done, lost, cmd_out, cmd_oe
   );
endinterface : csr_tx_if

// ===== logic/csr_tx.sv
// response shifter on the command line
`timescale 1ns/1ps
module csr_tx (
   input wire logic clk_sys,
   input wire logic resetn,
   csr_tx_if.tx bus
);

   logic [135:0] sr;
   logic [7:0] cnt;
   logic [7:0] len;
   logic [2:0] gap;
   logic arb;

   // bits change on card clock falling edges, msb first
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sr <= 136'h0;
         cnt <= 8'h00;
         len <= 8'h00;
         gap <= 3'h0;
         arb <= 1'b0;
         bus.busy <= 1'b0;
         bus.done <= 1'b0;
         bus.lost <= 1'b0;
         bus.cmd_out <= 1'b1;
         bus.cmd_oe <= 1'b0;
      end else begin
         bus.done <= 1'b0;
         if (bus.start) begin
            sr <= bus.frame;
            len <= bus.len;
            gap <= bus.gap;
            arb <= bus.arb;
            cnt <= 8'h00;
            bus.busy <= 1'b1;
            bus.lost <= 1'b0;
         end else if (bus.busy) begin
            // open drain: a released one pulled low by another card
            if (bus.rise && arb && cnt != 8'h00 && bus.cmd_out && !bus.line) begin
               bus.busy <= 1'b0;
               bus.lost <= 1'b1;
               bus.done <= 1'b1;
               bus.cmd_oe <= 1'b0;
            end else if (bus.fall) begin
               if (gap != 3'h0) begin
                  gap <= gap - 3'h1;
               end else if (cnt == len) begin
                  bus.busy <= 1'b0;
                  bus.done <= 1'b1;
                  bus.cmd_out <= 1'b1;
                  bus.cmd_oe <= 1'b0;
               end else begin
                  bus.cmd_out <= sr[135];
                  bus.cmd_oe <= arb ? ~sr[135] : 1'b1;
                  sr <= {sr[134:0], 1'b0};
                  cnt <= cnt + 8'h01;
               end
            end
         end
      end
   end

endmodule : csr_tx

// ===== logic/csr_card.sv
// card state machine, command receiver and response framer with apb registers
//
// Overview of operation
// - go-idle from all states but inactive
// - CMD1: ready, busy idle, else inactive
// - CMD2 winner identified, CMD3 to standby
// - CMD7 addressed: select or reprogram
// - CMD7 other card: drop back to standby/disconnect
// - unlisted commands ignored, state kept
// - responses on command line, msb first
// - R1 is 48 bits with crc
// - busy on data line only when the command enters programming
// - R2 is 136 bits, end replaces bit0
// - CID for CMD2/CMD10, CSD for CMD9
// - R3 carries OCR with busy bit
// - status register copied into every R1
// - response bits set with same command
// - previous-command bits cleared one command later
// - state bits live, read bits clear
`timescale 1ns/1ps
`include "csr_defs.svh"
module csr_card (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cclk,
   input wire logic cmd_in,
   output wire logic cmd_out,
   output wire logic cmd_oe,
   output logic dat0_out,
   output logic dat0_oe
);

   localparam logic [31:0] OCR_VAL = `CSR_OCR;

   csr_tx_if tx_if ();
   csr_tx u_tx (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .bus(tx_if.tx)
   );
   assign cmd_out = tx_if.cmd_out;
   assign cmd_oe = tx_if.cmd_oe;

   // ****************************************************************
   // link synchronisers
   // ****************************************************************
   logic cclk_s1, cclk_s2, cclk_s3, cmd_s1, cmd_s2;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cclk_s1 <= 1'b0;
         cclk_s2 <= 1'b0;
         cclk_s3 <= 1'b0;
         cmd_s1 <= 1'b1;
         cmd_s2 <= 1'b1;
      end else begin
         cclk_s1 <= cclk;
         cclk_s2 <= cclk_s1;
         cclk_s3 <= cclk_s2;
         cmd_s1 <= cmd_in;
         cmd_s2 <= cmd_s1;
      end
   end
   assign tx_if.rise = cclk_s2 & ~cclk_s3;
   assign tx_if.fall = ~cclk_s2 & cclk_s3;
   assign tx_if.line = cmd_s2;

   // ****************************************************************
   // command receiver
   // ****************************************************************
   logic rx_on, rx_done;
   logic [5:0] rx_cnt;
   logic [47:0] rx_sr;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_on <= 1'b0;
         rx_done <= 1'b0;
         rx_cnt <= 6'h00;
         rx_sr <= 48'h0;
      end else begin
         rx_done <= 1'b0;
         if (tx_if.rise) begin
            if (rx_on) begin
               rx_sr <= {rx_sr[46:0], cmd_s2};
               rx_cnt <= rx_cnt + 6'h01;
               if (rx_cnt == 6'h2f) begin
                  rx_on <= 1'b0;
                  rx_done <= 1'b1;
               end
            end else if (!tx_if.busy && !cmd_s2) begin
               rx_on <= 1'b1;
               rx_cnt <= 6'h01;
               rx_sr <= 48'h0;
            end
         end
      end
   end

   logic frame_ok, cmd_fire, crc_bad, addr_hit;
   logic [5:0] idx;
   logic [31:0] arg;
   logic [15:0] rca;
   assign idx = rx_sr[45:40];
   assign arg = rx_sr[39:8];
   assign frame_ok = rx_sr[46] & rx_sr[0] & (csr_pkg::crc7_of(rx_sr[47:8]) == rx_sr[7:1]);
   assign cmd_fire = rx_done & frame_ok;
   assign crc_bad = rx_done & ~frame_ok;
   assign addr_hit = arg[31:16] == rca;

   // ****************************************************************
   // registers reached over apb
   // ****************************************************************
   logic [2:0] ctrl;
   logic [31:0] idreg [0:7];
   logic [31:0] last_arg;
   logic apb_fire, op_done;
   logic [31:0] xset;
   csr_pkg::csr_state_e state;
   logic [31:0] status_now;
   logic pwr_ready, volt_ok;
   logic [127:0] cid, csd;
   assign pwr_ready = ctrl[`CSR_CTRL_PWR];
   assign volt_ok = ctrl[`CSR_CTRL_VOLT];
   assign cid = {idreg[3], idreg[2], idreg[1], idreg[0]};
   assign csd = {idreg[7], idreg[6], idreg[5], idreg[4]};
   assign apb_fire = psel & penable & pready;
   assign op_done = apb_fire & pwrite & (paddr == `CSR_APB_CTRL) & pwdata[`CSR_CTRL_DONE];
   // execution errors come from the flash side and wait for the next R1 or R1b response
   assign xset = (apb_fire && pwrite && paddr == `CSR_APB_XSET) ?
                 (pwdata & `CSR_C_MASK) : 32'h0;

   logic [31:0] rd_data;
   logic rd_err;
   always_comb begin
      rd_data = 32'h0;
      rd_err = 1'b0;
      if (paddr[7:5] == `CSR_APB_ID_PAGE) begin
         rd_data = idreg[paddr[4:2]];
      end else begin
         case (paddr)
            `CSR_APB_CTRL: rd_data = {29'h0, ctrl};
            `CSR_APB_STATUS: rd_data = status_now;
            `CSR_APB_XSET: rd_data = 32'h0;
            `CSR_APB_INFO: rd_data = {rca, 2'h0, idx, 4'h0, state};
            `CSR_APB_ARG: rd_data = last_arg;
            default: rd_err = 1'b1;
         endcase
      end
   end

   // one wait state, then the answer
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & rd_err;
         prdata <= (psel && penable && !pready && !pwrite) ? rd_data : 32'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl <= `CSR_CTRL_RST;
         for (int i = 0; i < 8; i++) begin
            idreg[i] <= 32'h0;
         end
      end else if (apb_fire && pwrite) begin
         if (paddr == `CSR_APB_CTRL) begin
            ctrl <= pwdata[2:0];
         end
         if (paddr[7:5] == `CSR_APB_ID_PAGE) begin
            idreg[paddr[4:2]] <= pwdata;
         end
      end
   end

   // ****************************************************************
   // command decode
   // ****************************************************************
   function automatic logic on_bus(input csr_pkg::csr_state_e s);
      return s inside {csr_pkg::ST_STBY, csr_pkg::ST_TRAN, csr_pkg::ST_DATA,
                       csr_pkg::ST_RCV, csr_pkg::ST_PRG, csr_pkg::ST_DIS};
   endfunction : on_bus

   csr_pkg::csr_state_e next_state;
   csr_pkg::csr_resp_e rtype;
   logic legal;
   logic in_tran;
   assign in_tran = state == csr_pkg::ST_TRAN;
   always_comb begin
      next_state = state;
      rtype = csr_pkg::R_NONE;
      legal = 1'b0;
      case (idx)
         6'd0: if (state != csr_pkg::ST_INA) begin
            legal = 1'b1;
            next_state = csr_pkg::ST_IDLE;
         end
         6'd1: if (state == csr_pkg::ST_IDLE) begin
            legal = 1'b1;
            if (!volt_ok) begin
               next_state = csr_pkg::ST_INA;
            end else begin
               rtype = csr_pkg::R_R3;
               if (pwr_ready) begin
                  next_state = csr_pkg::ST_READY;
               end
            end
         end
         6'd2: if (state == csr_pkg::ST_READY) begin
            legal = 1'b1;
            rtype = csr_pkg::R_CID;
         end
         6'd3: if (state == csr_pkg::ST_IDENT) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1;
            next_state = csr_pkg::ST_STBY;
         end
         6'd4: legal = state == csr_pkg::ST_STBY;
         6'd7: if (addr_hit) begin
            if (state == csr_pkg::ST_STBY || state == csr_pkg::ST_DIS) begin
               legal = 1'b1;
               rtype = csr_pkg::R_R1B;
               next_state = (state == csr_pkg::ST_STBY) ? csr_pkg::ST_TRAN : csr_pkg::ST_PRG;
            end
         end else if (state inside {csr_pkg::ST_TRAN, csr_pkg::ST_DATA}) begin
            legal = 1'b1;
            next_state = csr_pkg::ST_STBY;
         end else if (state == csr_pkg::ST_PRG) begin
            legal = 1'b1;
            next_state = csr_pkg::ST_DIS;
         end
         6'd9, 6'd10: if (state == csr_pkg::ST_STBY && addr_hit) begin
            legal = 1'b1;
            rtype = (idx == 6'd9) ? csr_pkg::R_CSD : csr_pkg::R_CID;
         end
         6'd12: if (state inside {csr_pkg::ST_DATA, csr_pkg::ST_RCV}) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1B;
            next_state = (state == csr_pkg::ST_DATA) ? csr_pkg::ST_TRAN : csr_pkg::ST_PRG;
         end
         6'd13: if (on_bus(state) && addr_hit) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1;
         end
         6'd15: if (on_bus(state) && addr_hit) begin
            legal = 1'b1;
            next_state = csr_pkg::ST_INA;
         end
         6'd11, 6'd17, 6'd18, 6'd30: if (in_tran) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1;
            next_state = csr_pkg::ST_DATA;
         end
         6'd16, 6'd23, 6'd32, 6'd33, 6'd34, 6'd35, 6'd36, 6'd37: if (in_tran) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1;
         end
         6'd20, 6'd26, 6'd27, 6'd42: if (in_tran) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1;
            next_state = csr_pkg::ST_RCV;
         end
         6'd24, 6'd25: if (in_tran || state == csr_pkg::ST_PRG) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1;
            next_state = csr_pkg::ST_RCV;
         end
         6'd28, 6'd29, 6'd38: if (in_tran) begin
            legal = 1'b1;
            rtype = csr_pkg::R_R1B;
            next_state = csr_pkg::ST_PRG;
         end
         default: legal = 1'b0;
      endcase
   end

   // ****************************************************************
   // card state
   // ****************************************************************
   logic accept, cid_pend;
   assign accept = cmd_fire & legal;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state <= csr_pkg::ST_IDLE;
         cid_pend <= 1'b0;
         rca <= `CSR_RCA_RST;
         last_arg <= 32'h0;
      end else begin
         if (accept) begin
            state <= next_state;
            cid_pend <= idx == 6'd2;
            last_arg <= arg;
            if (idx == 6'd3) begin
               rca <= arg[31:16];
            end
         end else if (cid_pend && tx_if.done) begin
            cid_pend <= 1'b0;
            if (!tx_if.lost) begin
               state <= csr_pkg::ST_IDENT;
            end
         end else if (op_done) begin
            case (state)
               csr_pkg::ST_DATA: state <= csr_pkg::ST_TRAN;
               csr_pkg::ST_PRG: state <= csr_pkg::ST_TRAN;
               csr_pkg::ST_DIS: state <= csr_pkg::ST_STBY;
               default: state <= state;
            endcase
         end
      end
   end

   // ****************************************************************
   // status bits
   // ****************************************************************
   logic [31:0] stat_c;
   logic [1:0] stat_b;
   logic r1_out;
   assign r1_out = accept & (rtype == csr_pkg::R_R1 || rtype == csr_pkg::R_R1B);
   assign status_now = stat_c
      | (32'(ctrl[`CSR_CTRL_LOCK]) << `CSR_ST_LOCKED)
      | (32'(stat_b[1]) << `CSR_ST_COM_CRC)
      | (32'(stat_b[0]) << `CSR_ST_ILLEGAL)
      | (32'(state) << `CSR_ST_STATE_LSB)
      | (32'(state != csr_pkg::ST_RCV) << `CSR_ST_BUF_EMPTY);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stat_b <= 2'h0;
      end else if (accept) begin
         stat_b <= 2'h0;
      end else begin
         stat_b <= stat_b | {crc_bad, cmd_fire & ~legal};
      end
   end

   // reported bits clear, a new event in the same cycle stays set
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stat_c <= 32'h0;
      end else if (r1_out) begin
         stat_c <= xset;
      end else begin
         stat_c <= stat_c | xset;
      end
   end

   // ****************************************************************
   // response framing
   // ****************************************************************
   logic [39:0] r1_head;
   assign r1_head = {2'h0, idx, status_now};
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tx_if.start <= 1'b0;
         tx_if.frame <= 136'h0;
         tx_if.len <= 8'h00;
         tx_if.gap <= 3'h0;
         tx_if.arb <= 1'b0;
      end else begin
         tx_if.start <= accept & (rtype != csr_pkg::R_NONE);
         if (accept) begin
            tx_if.arb <= rtype == csr_pkg::R_CID && idx == 6'd2;
            tx_if.gap <= (idx == 6'd1 || idx == 6'd2) ? `CSR_N_ID : `CSR_N_CR;
            tx_if.len <= `CSR_LEN_SHORT;
            case (rtype)
               csr_pkg::R_R3: tx_if.frame <= {`CSR_R3_HEAD, pwr_ready, OCR_VAL[30:0],
                                              `CSR_R3_TAIL, 88'h0};
               csr_pkg::R_CID: begin
                  tx_if.frame <= {`CSR_R2_HEAD, cid[127:1], 1'b1};
                  tx_if.len <= `CSR_LEN_LONG;
               end
               csr_pkg::R_CSD: begin
                  tx_if.frame <= {`CSR_R2_HEAD, csd[127:1], 1'b1};
                  tx_if.len <= `CSR_LEN_LONG;
               end
               default: tx_if.frame <= {r1_head, csr_pkg::crc7_of(r1_head), 1'b1,
                                        88'h0};
            endcase
         end
      end
   end

   // busy on the data line while programming
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dat0_out <= 1'b0;
         dat0_oe <= 1'b0;
      end else begin
         dat0_out <= 1'b0;
         dat0_oe <= state == csr_pkg::ST_PRG;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   a_go_idle: assert property (cmd_fire && idx == 6'd0 && state != csr_pkg::ST_INA
      |=> state == csr_pkg::ST_IDLE) else $error("go-idle missed");
   a_ina_stays: assert property (state == csr_pkg::ST_INA |=> state == csr_pkg::ST_INA)
      else $error("inactive card left inactive");
   a_cmd1_ready: assert property (cmd_fire && idx == 6'd1 && state == csr_pkg::ST_IDLE
      && volt_ok && pwr_ready |=> state == csr_pkg::ST_READY && tx_if.start)
      else $error("cmd1 did not reach ready with r3");
   a_cmd1_bad_volt: assert property (cmd_fire && idx == 6'd1 && state == csr_pkg::ST_IDLE
      && !volt_ok |=> state == csr_pkg::ST_INA && !tx_if.start)
      else $error("cmd1 bad range not inactive");
   a_cmd7_select: assert property (cmd_fire && idx == 6'd7 && addr_hit
      && state == csr_pkg::ST_STBY |=> state == csr_pkg::ST_TRAN)
      else $error("cmd7 select failed");
   a_cmd7_deselect: assert property (cmd_fire && idx == 6'd7 && !addr_hit
      && state == csr_pkg::ST_PRG |=> state == csr_pkg::ST_DIS)
      else $error("cmd7 deselect failed");
   a_illegal_ignored: assert property (cmd_fire && !legal |=> $stable(state) && !tx_if.start)
      else $error("illegal command acted on");
   a_short_frame: assert property (tx_if.start && tx_if.len == `CSR_LEN_SHORT
      |-> tx_if.frame[135:134] == 2'h0 && tx_if.frame[88]) else $error("short frame malformed");
   a_prev_clear: assert property (accept ##1 !crc_bad && !cmd_fire |-> stat_b == 2'h0)
      else $error("previous-command bits kept");
   a_crc_flag: assert property (crc_bad |=> stat_b[1]) else $error("crc error not flagged");

   cp_ready: cover property (state == csr_pkg::ST_IDLE ##1 state == csr_pkg::ST_READY);
   cp_arb_lost: cover property (cid_pend && tx_if.done && tx_if.lost);
   cp_busy: cover property (dat0_oe);
   cp_crc_bad: cover property (crc_bad);

endmodule : csr_card

// ===== tb/csr_host_model.sv
// host controller model driving the card command line
`timescale 1ns/1ps
module csr_host_model (
   input wire logic clk_sys,
   input wire logic line,
   output logic cclk,
   output logic h_bit,
   output logic h_oe
);
   initial begin
      cclk = 1'b0;
      h_bit = 1'b1;
      h_oe = 1'b0;
   end
   function automatic logic [6:0] crc(input logic [39:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction : crc
   // clock stands low outside frames, 80 ns period
   task automatic half();
      repeat (10) @(posedge clk_sys);
      cclk <= ~cclk;
   endtask : half
   // bad flips the crc lsb to make a corrupted command
   task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input int len,
                      input logic bad, output logic [135:0] r, output logic got);
      logic [47:0] f;
      f = {2'b01, idx, arg, crc({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
      got = 1'b0;
      r = '1;
      h_oe <= 1'b1;
      for (int i = 47; i >= 0; i--) begin
         h_bit <= f[i];
         half();
         half();
      end
      h_oe <= 1'b0;
      h_bit <= 1'b1;
      for (int w = 0; w < 80 && !got; w++) begin
         half();
         @(negedge clk_sys);
         got = (line === 1'b0);
         half();
      end
      if (got) begin
         r = '0;
         for (int k = 1; k < len; k++) begin
            half();
            @(negedge clk_sys);
            r = {r[134:0], line};
            half();
         end
      end
      repeat (16) half();
   endtask : cmd
endmodule : csr_host_model

// ===== tb/testbench.sv
// self-checking bench of the card state machine and responses
`timescale 1ns/1ps
module testbench;
   logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err, got;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic cclk, cmd_out, cmd_oe, dat0_out, dat0_oe, h_bit, h_oe;
   logic [135:0] rsp;
   int failures, cmp_count;
   wire logic line = (cmd_oe ? cmd_out : 1'b1) & (h_oe ? h_bit : 1'b1);
   csr_card dut_u (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cclk(cclk), .cmd_in(line), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
      .dat0_out(dat0_out), .dat0_oe(dat0_oe));
   csr_host_model host_u (.clk_sys(clk_sys), .line(line), .cclk(cclk), .h_bit(h_bit),
      .h_oe(h_oe));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [135:0] seen, input logic [135:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic go(input logic [5:0] idx, input logic [31:0] arg, input int len);
      host_u.cmd(idx, arg, len, 1'b0, rsp, got);
   endtask : go
   task automatic st(input logic [3:0] e);
      apb(1'b0, 8'h0c, 32'h0);
      chk("state", q[3:0], e);
   endtask : st
   function automatic logic [47:0] r1(input logic [5:0] i, input logic [31:0] s);
      return {2'b00, i, s, host_u.crc({2'b00, i, s}), 1'b1};
   endfunction : r1
   task automatic t_init();
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", q, 32'h2);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", err, 1'b1);
      go(6'h01, 32'h00ff8000, 48);
      chk("r3 busy", rsp[47:0], 48'h3f00ff8000ff);
      st(csr_pkg::ST_IDLE);
      apb(1'b1, 8'h00, 32'h3);
      go(6'h01, 32'h00ff8000, 48);
      chk("r3 ready", rsp[47:0], 48'h3f80ff8000ff);
      st(csr_pkg::ST_READY);
      $display("test init done");
   endtask : t_init
   task automatic t_ident();
      logic [127:0] cid;
      for (int i = 0; i < 4; i++) begin
         cid[i*32 +: 32] = 32'h11111111 * (i + 1);
         apb(1'b1, 8'h20 + 8'(4 * i), cid[i*32 +: 32]);
      end
      go(6'h02, 32'h0, 136);
      chk("r2 cid", rsp, {8'h3f, cid[127:1], 1'b1});
      st(csr_pkg::ST_IDENT);
      go(6'h03, 32'h00010000, 48);
      chk("r1 cmd3", rsp[47:0], r1(6'h03, 32'h00000500));
      st(csr_pkg::ST_STBY);
      $display("test ident done");
   endtask : t_ident
   task automatic t_illegal();
      go(6'h10, 32'h200, 48);
      chk("no resp", got, 1'b0);
      st(csr_pkg::ST_STBY);
      go(6'h0d, 32'h00010000, 48);
      chk("illegal set", rsp[47:0], r1(6'h0d, 32'h00400700));
      apb(1'b1, 8'h08, 32'h80000000);
      host_u.cmd(6'h0d, 32'h00010000, 48, 1'b1, rsp, got);
      chk("crc no resp", got, 1'b0);
      go(6'h0d, 32'h00010000, 48);
      chk("crc read", rsp[47:0], r1(6'h0d, 32'h80800700));
      go(6'h0d, 32'h00010000, 48);
      chk("illegal clr", rsp[47:0], r1(6'h0d, 32'h00000700));
      $display("test illegal done");
   endtask : t_illegal
   task automatic t_select();
      go(6'h07, 32'h00010000, 48);
      chk("r1b cmd7", rsp[47:0], r1(6'h07, 32'h00000700));
      st(csr_pkg::ST_TRAN);
      go(6'h1c, 32'h0, 48);
      st(csr_pkg::ST_PRG);
      chk("busy", {dat0_oe, dat0_out}, 2'b10);
      apb(1'b1, 8'h00, 32'hb);
      st(csr_pkg::ST_TRAN);
      chk("idle dat0", dat0_oe, 1'b0);
      go(6'h11, 32'h0, 48);
      st(csr_pkg::ST_DATA);
      go(6'h07, 32'h00020000, 48);
      chk("deselect", got, 1'b0);
      st(csr_pkg::ST_STBY);
      go(6'h00, 32'h0, 48);
      st(csr_pkg::ST_IDLE);
      $display("test select done");
   endtask : t_select
   task automatic t_inactive();
      apb(1'b1, 8'h00, 32'h1);
      go(6'h01, 32'h00ff8000, 48);
      chk("cmd1 bad range", got, 1'b0);
      st(csr_pkg::ST_INA);
      go(6'h00, 32'h0, 48);
      st(csr_pkg::ST_INA);
      resetn <= 1'b0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      st(csr_pkg::ST_IDLE);
      $display("test inactive done");
   endtask : t_inactive
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (80000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_init();
      t_ident();
      t_illegal();
      t_select();
      t_inactive();
      end_sim();
   end
endmodule : testbench
